// *** dv/spg_link_master.sv ***
// partner model: external serial master making the link clock and capturing transmit data
`timescale 1ns/1ps
`default_nettype none
module spg_link_master (
    input  wire logic        clk,
    input  wire logic        run,
    input  wire logic        listen,
    input  wire logic        sdo,
    output logic             sclk,
    output logic [31:0]      rx
);
    logic [2:0] phase;
    // link clock of eight system cycles, idle low and still while not running
    always_ff @(posedge clk) begin
        phase <= run ? phase + 3'h1 : 3'h0;
        sclk  <= run && (phase < 3'h4);
        if (run && listen && phase == 3'h7) begin
            rx <= {rx[30:0], sdo}; // first bit lands highest
        end
    end
endmodule
`default_nettype wire

// *** dv/test_spg_top.sv ***
// testbench: apb register access, gap and debug halt behaviour of the spi transmit path
`timescale 1ns/1ps
`default_nettype none
module test_spg_top;
    import spg_pkg::*;
    logic              clk, nrst, psel, penable, pwrite, halt, run, listen, last_err;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic              pready, pslverr, sclk, sdo;
    logic [31:0]       rx;
    int                miscompares, samples_checked;

    spg_top dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_clock_pin(sclk), .debug_halt_request(halt), .serial_data_out(sdo));
    spg_link_master link (.clk(clk), .run(run), .listen(listen), .sdo(sdo), .sclk(sclk),
        .rx(rx));

    // clock generation
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic results;
        if (miscompares == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t mismatch got %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, then one idle cycle
    task automatic apb(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {14'h0, idx, 2'h0};
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            $display("[ERR] %0t apb transfer timed out", $time);
            results();
        end
        rd       = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    // n link clock pulses
    task automatic pulses(input int n, input logic lst);
        listen <= lst;
        run    <= 1'b1;
        repeat (n * 8) @(posedge clk);
        run    <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    initial begin
        {nrst, psel, penable, pwrite, halt, run, listen} = '0;
        paddr = '0;
        pwdata = '0;
        miscompares = 0;
        samples_checked = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        apb(1'b0, IDX_GAP_CTRL, 32'h0);
        check(rd, 32'h0000_0000);
        apb(1'b0, IDX_SUSP_CTRL, 32'h0);
        check(rd, 32'h0000_0000);
        apb(1'b1, IDX_SUSP_CTRL, 32'hFFFF_FFFF);
        apb(1'b0, IDX_SUSP_CTRL, 32'h0);
        check(rd, 32'h0000_0030);
        apb(1'b1, IDX_GAP_CTRL, 32'h0000_01FF);
        apb(1'b0, IDX_GAP_CTRL, 32'h0);
        check(rd, 32'h0000_00FF);
        apb(1'b0, 16'h7050, 32'h0);
        check({rd[30:0], last_err}, 32'h0000_0001);
        // free run: halt ignored
        halt <= 1'b1;
        apb(1'b1, IDX_TX_DATA, 32'h0000_00A5);
        pulses(8, 1'b1);
        check({24'h0, rx[7:0]}, 32'hA5);
        halt <= 1'b0;
        // freeze mid-word, then resume
        apb(1'b1, IDX_SUSP_CTRL, 32'h0);
        apb(1'b1, IDX_TX_DATA, 32'h0000_003C);
        pulses(3, 1'b1);
        halt <= 1'b1;
        pulses(5, 1'b0);
        apb(1'b0, IDX_STATUS, 32'h0);
        check(rd & 32'h40, 32'h40);
        halt <= 1'b0;
        pulses(5, 1'b1);
        check({24'h0, rx[7:0]}, 32'h3C);
        // soft stop before the first pulse blocks the word
        apb(1'b1, IDX_SUSP_CTRL, 32'h0000_0020);
        apb(1'b1, IDX_TX_DATA, 32'h0000_0096);
        halt <= 1'b1;
        pulses(8, 1'b0);
        apb(1'b0, IDX_STATUS, 32'h0);
        check(rd & 32'h41, 32'h41);
        halt <= 1'b0;
        pulses(8, 1'b1);
        check({24'h0, rx[7:0]}, 32'h96);
        // soft stop after the first pulse drains shifter and holding buffer
        apb(1'b1, IDX_TX_DATA, 32'h0000_00C3);
        apb(1'b1, IDX_TX_DATA, 32'h0000_005A);
        pulses(1, 1'b1);
        halt <= 1'b1;
        pulses(15, 1'b1);
        check({16'h0, rx[15:0]}, 32'hC35A);
        apb(1'b0, IDX_STATUS, 32'h0);
        check(rd & 32'h43, 32'h40);
        halt <= 1'b0;
        // fifo mode, zero gap, soft stop drains the fifo
        apb(1'b1, IDX_MODE_CTRL, 32'h0000_0001);
        apb(1'b1, IDX_GAP_CTRL, 32'h0);
        apb(1'b1, IDX_TX_DATA, 32'h0000_0011);
        apb(1'b1, IDX_TX_DATA, 32'h0000_00E7);
        apb(1'b1, IDX_TX_DATA, 32'h0000_0081);
        pulses(1, 1'b1);
        halt <= 1'b1;
        pulses(23, 1'b1);
        check({8'h0, rx[23:0]}, 32'h11E781);
        halt <= 1'b0;
        // fifo mode with a gap of three link clocks
        apb(1'b1, IDX_GAP_CTRL, 32'h0000_0003);
        apb(1'b1, IDX_TX_DATA, 32'h0000_00B4);
        apb(1'b1, IDX_TX_DATA, 32'h0000_004D);
        pulses(19, 1'b1);
        check({16'h0, rx[18:11], rx[7:0]}, 32'hB44D);
        results();
    end
endmodule
`default_nettype wire

// *** logic/spg_fifo.sv ***
// small transmit fifo holding words ahead of the shift register
`timescale 1ns/1ps
`default_nettype none
module spg_fifo
    import spg_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 nrst,
    input  wire logic                 push,
    input  wire logic [WORD_BITS-1:0] push_data,
    input  wire logic                 pop,
    output logic      [WORD_BITS-1:0] pop_data,
    output logic      [CNT_W-1:0]     count,
    output logic                      full,
    output logic                      empty
);
    logic [WORD_BITS-1:0] mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0]   wptr;
    logic [FIFO_AW-1:0]   next_wptr;
    logic [FIFO_AW-1:0]   rptr;
    logic [FIFO_AW-1:0]   next_rptr;
    logic [CNT_W-1:0]     next_count;
    logic                 do_push;
    logic                 do_pop;

    // pointer and count update; refused push or pop changes nothing
    always_comb begin
        do_push    = push & ~full;
        do_pop     = pop & ~empty;
        next_wptr  = do_push ? wptr + 1'b1 : wptr;
        next_rptr  = do_pop ? rptr + 1'b1 : rptr;
        next_count = count;
        if (do_push && !do_pop) begin
            next_count = count + CNT_ONE;
        end else if (do_pop && !do_push) begin
            next_count = count - CNT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            wptr  <= '0;
            rptr  <= '0;
            count <= '0;
        end else begin
            wptr  <= next_wptr;
            rptr  <= next_rptr;
            count <= next_count;
        end
    end

    // storage array, written only on an accepted push
    always_ff @(posedge clk) begin
        if (do_push) begin
            mem[wptr] <= push_data;
        end
    end

    assign pop_data = mem[rptr];
    assign full     = (count == CNT_FULL);
    assign empty    = (count == '0);
endmodule
`default_nettype wire

// *** logic/spg_pkg.sv ***
// package: constants, types and address decode for the spi tx gap / debug halt block
package spg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // widths and depths
    localparam int ADDR_W     = 32;
    localparam int DATA_W     = 32;
    localparam int WORD_BITS  = 8;
    localparam int BITS_W     = 4;
    localparam int GAP_W      = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int FIFO_AW    = 2;
    localparam int CNT_W      = 3;
    localparam int IDX_W      = 16;
    localparam int IDX_SHIFT  = 2;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; the byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_GAP_CTRL  = 16'h704C;
    localparam logic [IDX_W-1:0] IDX_SUSP_CTRL = 16'h704F;
    localparam logic [IDX_W-1:0] IDX_MODE_CTRL = 16'h7040;
    localparam logic [IDX_W-1:0] IDX_TX_DATA   = 16'h7041;
    localparam logic [IDX_W-1:0] IDX_STATUS    = 16'h7042;

    ////////////////////////////////////////////////////////////////////////////
    // field positions, reset values and counting constants
    localparam int SUSP_FREE_POS = 4;
    localparam int SUSP_SOFT_POS = 5;
    localparam int MODE_FIFO_POS = 0;
    localparam logic [GAP_W-1:0]  GAP_RST   = 8'h00;
    localparam logic [GAP_W-1:0]  GAP_ONE   = 8'h01;
    localparam logic [BITS_W-1:0] WORD_LEN  = 4'h8;
    localparam logic [BITS_W-1:0] BIT_ONE   = 4'h1;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 3'h1;
    localparam logic [CNT_W-1:0]  CNT_FULL  = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [1:0] {
        SPG_IDLE  = 2'b00,
        SPG_SHIFT = 2'b01,
        SPG_GAP   = 2'b10
    } spg_state_t;

    typedef struct packed {
        logic             halted;
        logic             draining;
        logic [CNT_W-1:0] fifo_count;
        logic             hold_full;
        logic             busy;
    } spg_status_t;

    // word-aligned hit on one register index
    function automatic logic spg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [IDX_W-1:0]  idx);
        return (addr[ADDR_W-1:IDX_W+IDX_SHIFT] == '0) &&
               (addr[IDX_SHIFT-1:0] == '0) &&
               (addr[IDX_W+IDX_SHIFT-1:IDX_SHIFT] == idx);
    endfunction

endpackage

// *** logic/spg_sync.sv ***
// two-flop synchroniser with rising-edge detect for the serial clock pin
`timescale 1ns/1ps
`default_nettype none
module spg_sync
    import spg_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic async_in,
    output logic      rise
);
    logic meta;
    logic next_meta;
    logic sync;
    logic next_sync;
    logic last;
    logic next_last;

    // sample chain; meta is read by sync alone
    always_comb begin
        next_meta = async_in;
        next_sync = meta;
        next_last = sync;
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else begin
            meta <= next_meta;
            sync <= next_sync;
            last <= next_last;
        end
    end

    // one-cycle pulse per serial clock rising edge
    assign rise = sync & ~last;
endmodule
`default_nettype wire

// *** logic/spg_top.sv ***
// spi transmit path with fifo-mode inter-word gap and debug halt handling, apb registers
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module spg_top
    import spg_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output var  logic [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              serial_clock_pin,
    input  wire logic              debug_halt_request,
    output var  logic              serial_data_out
);
    logic [GAP_W-1:0]     tx_gap_cycles;
    logic [GAP_W-1:0]     next_gap_cycles;
    logic                 halt_soft_bit;
    logic                 next_soft_bit;
    logic                 halt_free_bit;
    logic                 next_free_bit;
    logic                 fifo_mode;
    logic                 next_fifo_mode;
    logic [WORD_BITS-1:0] tx_holding_buffer;
    logic [WORD_BITS-1:0] next_holding;
    logic                 hold_full;
    logic                 next_hold_full;
    logic [WORD_BITS-1:0] shift_register;
    logic [WORD_BITS-1:0] next_shift;
    logic [BITS_W-1:0]    pending_shift_bits;
    logic [BITS_W-1:0]    next_pending;
    logic [GAP_W-1:0]     gap_left;
    logic [GAP_W-1:0]     next_gap_left;
    spg_state_t           state;
    spg_state_t           next_state;
    logic                 drain;
    logic                 next_drain;
    logic                 halt_d;
    logic                 next_halt_d;
    logic                 next_sdo;
    logic [DATA_W-1:0]    next_prdata;
    logic [DATA_W-1:0]    rd_mux;
    logic                 sclk_rise;
    logic                 wr_en;
    logic                 setup_rd;
    logic                 mapped;
    logic                 tx_push;
    logic                 fifo_push;
    logic                 fifo_pop;
    logic [WORD_BITS-1:0] fifo_data;
    logic [CNT_W-1:0]     fifo_count;
    logic                 fifo_full;
    logic                 fifo_empty;
    logic                 hold_write;
    logic                 hold_take;
    logic                 src_avail;
    logic                 soft_mode;
    logic                 freeze_mode;
    logic                 halt_rise;
    logic                 word_started;
    logic                 drain_now;
    logic                 run;
    logic                 load;
    spg_status_t          status;

    ////////////////////////////////////////////////////////////////////////////
    // serial clock pin sampling and transmit fifo

    spg_sync u_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in (serial_clock_pin),
        .rise     (sclk_rise)
    );

    spg_fifo u_fifo (
        .clk       (clk),
        .nrst      (nrst),
        .push      (fifo_push),
        .push_data (pwdata[WORD_BITS-1:0]),
        .pop       (fifo_pop),
        .pop_data  (fifo_data),
        .count     (fifo_count),
        .full      (fifo_full),
        .empty     (fifo_empty)
    );

    ////////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, unmapped access answers with pslverr

    assign wr_en    = psel & penable & pwrite;
    assign setup_rd = psel & ~penable & ~pwrite;
    assign mapped   = spg_hit(paddr, IDX_GAP_CTRL) | spg_hit(paddr, IDX_SUSP_CTRL) |
                      spg_hit(paddr, IDX_MODE_CTRL) | spg_hit(paddr, IDX_TX_DATA) |
                      spg_hit(paddr, IDX_STATUS);
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    assign tx_push  = wr_en & spg_hit(paddr, IDX_TX_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // halt response decode

    assign soft_mode    = halt_soft_bit & ~halt_free_bit;
    assign freeze_mode  = ~halt_soft_bit & ~halt_free_bit;
    assign halt_rise    = debug_halt_request & ~halt_d;
    assign word_started = (state == SPG_SHIFT) && (pending_shift_bits != WORD_LEN);
    assign drain_now    = drain | (halt_rise & word_started);
    // free runs always, freeze stops at once, soft runs only while draining
    assign run = halt_free_bit | ~debug_halt_request |
                 (soft_mode & drain_now);
    assign src_avail  = fifo_mode ? ~fifo_empty : hold_full;
    assign fifo_push  = tx_push & fifo_mode;
    assign fifo_pop   = load & fifo_mode;
    assign hold_take  = load & ~fifo_mode;
    assign hold_write = tx_push & ~fifo_mode & (~hold_full | hold_take);

    ////////////////////////////////////////////////////////////////////////////
    // register file next values

    always_comb begin
        next_gap_cycles = tx_gap_cycles;
        next_soft_bit   = halt_soft_bit;
        next_free_bit   = halt_free_bit;
        next_fifo_mode  = fifo_mode;
        next_holding    = hold_write ? pwdata[WORD_BITS-1:0] : tx_holding_buffer;
        next_hold_full  = (hold_full & ~hold_take) | hold_write; // write wins
        if (wr_en && spg_hit(paddr, IDX_GAP_CTRL)) begin
            next_gap_cycles = pwdata[GAP_W-1:0];
        end
        if (wr_en && spg_hit(paddr, IDX_SUSP_CTRL)) begin
            next_soft_bit = pwdata[SUSP_SOFT_POS];
            next_free_bit = pwdata[SUSP_FREE_POS];
        end
        if (wr_en && spg_hit(paddr, IDX_MODE_CTRL)) begin
            next_fifo_mode = pwdata[MODE_FIFO_POS];
        end
    end

    // read data captured in the setup cycle, stable through the access phase
    always_comb begin
        status.halted     = debug_halt_request & ~run;
        status.draining   = drain;
        status.fifo_count = fifo_count;
        status.hold_full  = hold_full;
        status.busy       = (state != SPG_IDLE);
        rd_mux = '0;
        if (spg_hit(paddr, IDX_GAP_CTRL)) begin
            rd_mux[GAP_W-1:0] = tx_gap_cycles;
        end
        if (spg_hit(paddr, IDX_SUSP_CTRL)) begin
            rd_mux[SUSP_SOFT_POS] = halt_soft_bit;
            rd_mux[SUSP_FREE_POS] = halt_free_bit;
        end
        if (spg_hit(paddr, IDX_MODE_CTRL)) begin
            rd_mux[MODE_FIFO_POS] = fifo_mode;
        end
        if (spg_hit(paddr, IDX_STATUS)) begin
            rd_mux[$bits(spg_status_t)-1:0] = status;
        end
        next_prdata = setup_rd ? rd_mux : prdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    // soft-stop drain tracking

    always_comb begin
        next_halt_d = debug_halt_request;
        next_drain  = drain;
        if (!debug_halt_request || !soft_mode) begin
            next_drain = 1'b0;
        end else if (halt_rise && word_started) begin
            next_drain = 1'b1;
        end else if (drain && state == SPG_IDLE && !src_avail) begin
            next_drain = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shifter and gap sequencer; nothing advances while run is low

    always_comb begin
        next_state    = state;
        next_shift    = shift_register;
        next_pending  = pending_shift_bits;
        next_gap_left = gap_left;
        next_sdo      = serial_data_out;
        load          = 1'b0;
        unique case (state)
            SPG_IDLE: begin
                load = run & src_avail;
            end
            SPG_SHIFT: begin
                if (run && sclk_rise) begin
                    next_sdo     = shift_register[WORD_BITS-1];
                    next_shift   = {shift_register[WORD_BITS-2:0], 1'b0};
                    next_pending = pending_shift_bits - BIT_ONE;
                    if (pending_shift_bits == BIT_ONE) begin
                        if (fifo_mode && tx_gap_cycles != GAP_RST) begin
                            next_state    = SPG_GAP;
                            next_gap_left = tx_gap_cycles;
                        end else begin
                            next_state = SPG_IDLE;
                            load       = src_avail;
                        end
                    end
                end
            end
            SPG_GAP: begin
                if (run && sclk_rise) begin
                    next_gap_left = gap_left - GAP_ONE;
                    if (gap_left == GAP_ONE) begin
                        next_state = SPG_IDLE;
                        load       = src_avail;
                    end
                end
            end
            default: begin
                next_state = SPG_IDLE;
            end
        endcase
        if (load) begin
            next_state   = SPG_SHIFT;
            next_shift   = fifo_mode ? fifo_data : tx_holding_buffer;
            next_pending = WORD_LEN;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state registers

    always_ff @(posedge clk) begin
        if (!nrst) begin
            tx_gap_cycles      <= GAP_RST;
            halt_soft_bit      <= 1'b0;
            halt_free_bit      <= 1'b0;
            fifo_mode          <= 1'b0;
            tx_holding_buffer  <= '0;
            hold_full          <= 1'b0;
            shift_register     <= '0;
            pending_shift_bits <= '0;
            gap_left           <= GAP_RST;
            state              <= SPG_IDLE;
            drain              <= 1'b0;
            halt_d             <= 1'b0;
            serial_data_out    <= 1'b0;
            prdata             <= '0;
        end else begin
            tx_gap_cycles      <= next_gap_cycles;
            halt_soft_bit      <= next_soft_bit;
            halt_free_bit      <= next_free_bit;
            fifo_mode          <= next_fifo_mode;
            tx_holding_buffer  <= next_holding;
            hold_full          <= next_hold_full;
            shift_register     <= next_shift;
            pending_shift_bits <= next_pending;
            gap_left           <= next_gap_left;
            state              <= next_state;
            drain              <= next_drain;
            halt_d             <= next_halt_d;
            serial_data_out    <= next_sdo;
            prdata             <= next_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_frozen;
        debug_halt_request && freeze_mode && state == SPG_SHIFT;
    endsequence
    sequence s_released;
        s_frozen ##1 !debug_halt_request;
    endsequence
    sequence s_last_bit;
        state == SPG_SHIFT && pending_shift_bits == BIT_ONE && run && sclk_rise;
    endsequence

    a_gap_field_write: assert property (
        wr_en && spg_hit(paddr, IDX_GAP_CTRL) |=> tx_gap_cycles == $past(pwdata[GAP_W-1:0]))
        else $error("gap field not taken from write data");
    a_gap_count_load: assert property (
        state == SPG_GAP && $past(state) == SPG_SHIFT |-> gap_left == $past(tx_gap_cycles))
        else $error("gap counter not loaded with programmed value");
    a_susp_reserved_zero: assert property (
        setup_rd && spg_hit(paddr, IDX_SUSP_CTRL) |=> prdata[3:0] == 4'h0 && prdata[7:6] == 2'h0)
        else $error("reserved suspend bits read non-zero");
    a_freeze_holds: assert property (
        s_frozen |=> $stable(pending_shift_bits) && $stable(shift_register) && $stable(serial_data_out))
        else $error("shifter moved while frozen");
    a_resume_next_bit: assert property (
        s_released |-> state == SPG_SHIFT && pending_shift_bits == $past(pending_shift_bits))
        else $error("frozen word lost bits on release");
    a_soft_no_start: assert property (
        soft_mode && debug_halt_request && !drain_now && state == SPG_IDLE |=> state == SPG_IDLE)
        else $error("word started under soft halt");
    a_soft_finish_word: assert property (
        soft_mode && halt_rise && word_started |=> drain)
        else $error("started word not allowed to finish");
    a_soft_std_drain: assert property (
        $fell(drain) && debug_halt_request && !fifo_mode |->
        $past(state) == SPG_IDLE && !$past(hold_full))
        else $error("soft stop before holding buffer emptied");
    a_soft_fifo_drain: assert property (
        $fell(drain) && debug_halt_request && fifo_mode |->
        $past(state) == SPG_IDLE && $past(fifo_empty))
        else $error("soft stop before fifo emptied");
    a_free_runs_on: assert property (
        halt_free_bit && state == SPG_SHIFT && pending_shift_bits != BIT_ONE && sclk_rise |=>
        pending_shift_bits == $past(pending_shift_bits) - BIT_ONE)
        else $error("free run mode stalled by halt");
    a_zero_gap_reload: assert property (
        s_last_bit ##0 (fifo_mode && tx_gap_cycles == GAP_RST && !fifo_empty) |=>
        state == SPG_SHIFT && pending_shift_bits == WORD_LEN)
        else $error("zero gap did not reload at once");

endmodule
`default_nettype wire

// *** logic/spg_top_end.sv ***
// spare design source; holds no logic
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
